/* File: rtl/flash_cmd_params.svh */
// opcodes, register offsets, field positions and limits of the flash command decoder
// assumes inclusion by bare name from the package and the decoder
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define OP_NO_OPERATION 8'h00
`define OP_RESET_ARM 8'h66
`define OP_RESET 8'h99
`define OP_QUAD_ON 8'h38
`define OP_QUAD_OFF 8'hFF
`define OP_READ_STATUS 8'h05
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_DUAL_OUT_READ 8'h3B
`define OP_DUAL_IO_READ 8'hBB
`define OP_QUAD_IO_READ 8'hEB
`define OP_SET_LATCH 8'h06
`define OP_CLEAR_LATCH 8'h04
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hD8
`define OP_ERASE_ALL_A 8'h60
`define OP_ERASE_ALL_B 8'hC7
`define OP_PAGE_PROGRAM 8'h02
`define OP_QUAD_PROGRAM 8'h32
`define OP_SUSPEND 8'hB0
`define OP_RESUME 8'h30
`define OP_LOCK_PROT 8'h8D
`define OP_READ_SID 8'h88
`define OP_PROGRAM_SID 8'hA5
`define OP_LOCK_SID 8'h85
`define OP_DEEP_SLEEP 8'hB9
`define OP_WAKE_ID 8'hAB

// ---------------------------------------------------------------
// array geometry and limits
// ---------------------------------------------------------------
`define TOP_ADDR_BIT 18
`define SECTOR_LOW_BIT 12
`define BLOCK32_LOW_BIT 15
`define BLOCK64_LOW_BIT 16
`define PAGE_MAX_BYTES 11'h100
`define SID_MAX_BYTES 11'h400
`define COUNT_SAT 11'h7FF
// identification byte value is arbitrary
`define WAKE_ID_BYTE 8'h5A

// ---------------------------------------------------------------
// register map (byte offsets) and fields
// ---------------------------------------------------------------
`define REG_CTRL 5'h00
`define REG_STATE 5'h04
`define REG_ADDR 5'h08
`define REG_CMD 5'h0C
`define REG_DATA 5'h10
`define REG_EXEC 5'h14
`define CTRL_QUAD_IO_EN 0
`define CTRL_BUSY_DONE 1
`define CMD_COUNT_LSB 16

`endif

/* File: rtl/flash_cmd_pkg.sv */
// types shared by the flash command decoder
// assumes flash_cmd_params.svh on the include path
`include "flash_cmd_params.svh"

package flash_cmd_pkg;

	// ---------------------------------------------------------------
	// phase machine, gray along idle-opcode-address-dummy-data-hold
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_OPCODE = 3'h1,
		PH_ADDR = 3'h3,
		PH_DUMMY = 3'h2,
		PH_DATA = 3'h6,
		PH_HOLD = 3'h7,
		PH_REJECT = 3'h5
	} phase_type;

	// shape of one instruction after its opcode
	typedef struct packed {
		logic ok;
		logic [1:0] addr_bytes;
		logic [1:0] dummy_bytes;
		logic has_data;
		logic data_out;
		logic [2:0] lanes_addr;
		logic [2:0] lanes_data;
	} cmd_info_type;

	// device state flags, also the layout of the state register
	typedef struct packed {
		logic quad_mode;
		logic reset_armed;
		logic deep_sleep;
		logic sid_locked;
		logic prot_locked;
		logic suspended;
		logic busy;
		logic write_latch;
	} flags_type;

endpackage : flash_cmd_pkg

/* File: rtl/flash_cmd_decoder.sv */
// serial flash command decoder: opcode, address, dummy and data phases, device state flags
// assumes serial pins arrive asynchronous to clk_i and are sampled here; sck well below clk_i/4
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "flash_cmd_params.svh"

// Overview of operation
// - opcode takes eight clocks single-bit, two clocks in quad mode
// - address, dummy, data bytes take eight clocks single-bit, two in quad
// - address bits above the top array bit are ignored
// - 20H with three address bytes erases the 4-Kbyte sector at A12 up
// - 52H with three address bytes erases the 32-Kbyte block at A15 up
// - D8H with three address bytes erases the 64-Kbyte block at A16 up
// - 60H or C7H erases the whole array, either mode
// - 06H sets and 04H clears the write latch, either mode
// - 02H with three address bytes programs 1 to 256 bytes, either mode
// - 32H single-bit only, quad data, needs quad I/O enable bit
// - B0H suspends a busy program or erase, 30H resumes it
// - 8DH locks down the protection settings
// - 88H reads security ID after two address bytes, one or three dummies
// - A5H programs 1 to 256 security ID bytes after two address bytes
// - 85H locks security ID programming until an armed reset clears it
// - B9H enters deep power-down
// - ABH wakes from deep power-down, three address bytes, then ID bytes
// - status read repeats status bytes until chip select rises
// - dual output read data, dual I/O address to data, four clocks per byte
// - quad I/O read in single-bit mode: two clocks per byte, needs enable bit
// - no-operation only cancels a pending reset arm
// - any command but 66H clears the reset arm; reset needs it armed
module flash_cmd_decoder (
	input wire logic clk_i, // 100 MHz system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic cs_n_pin_i, // chip select pin, active low
	input wire logic sck_pin_i, // serial clock pin
	input wire logic [3:0] sio_pin_i, // serial data lines, input side
	output logic [3:0] sio_o, // serial data lines, output side
	output logic [3:0] sio_oe_o, // serial data output enables
	input wire logic [4:0] avs_address_i, // register byte address
	input wire logic avs_read_i, // register read request
	input wire logic avs_write_i, // register write request
	input wire logic [31:0] avs_writedata_i, // register write data
	output logic [31:0] avs_readdata_o, // register read data
	output logic avs_waitrequest_o // high until the access completes
);

	// ---------------------------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------------------------
	logic [5:0] pin_s1_reg;
	logic [5:0] pin_s2_reg;
	logic sck_d_reg;
	logic cs_n_d_reg;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pin_s1_reg <= 6'h2D;
			pin_s2_reg <= 6'h2D;
			sck_d_reg <= 1'b0;
			cs_n_d_reg <= 1'b1;
		end else if (ce_i) begin
			pin_s1_reg <= {cs_n_pin_i, sck_pin_i, sio_pin_i};
			pin_s2_reg <= pin_s1_reg;
			sck_d_reg <= pin_s2_reg[4];
			cs_n_d_reg <= pin_s2_reg[5];
		end
	end

	wire logic cs_n = pin_s2_reg[5];
	wire logic [3:0] sio_in = pin_s2_reg[3:0];
	wire logic sck_rise = pin_s2_reg[4] & ~sck_d_reg & ~cs_n;
	wire logic sck_fall = ~pin_s2_reg[4] & sck_d_reg & ~cs_n;
	wire logic cs_rise = cs_n & ~cs_n_d_reg;
	wire logic cs_fall = ~cs_n & cs_n_d_reg;

	// ---------------------------------------------------------------
	// state and register declarations
	// ---------------------------------------------------------------
	flash_cmd_pkg::phase_type phase_reg;
	flash_cmd_pkg::cmd_info_type info_reg;
	flash_cmd_pkg::flags_type flags_reg;
	logic [2:0] lanes_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [1:0] left_reg;
	logic [7:0] op_reg;
	logic op_seen_reg;
	logic done_reg;
	logic [23:0] addr_reg;
	logic [10:0] count_reg;
	logic [7:0] out_sh_reg;
	logic [3:0] out_cnt_reg;
	logic quad_io_en_reg;
	logic [7:0] data_reg;
	logic [7:0] last_op_reg;
	logic last_ok_reg;
	logic [18:0] last_addr_reg;
	logic [10:0] last_count_reg;
	logic [15:0] exec_cnt_reg;

	// ---------------------------------------------------------------
	// opcode decode
	// ---------------------------------------------------------------
	function automatic flash_cmd_pkg::cmd_info_type decode(input logic [7:0] op,
		input logic quad, input logic quad_io_enable_bit, input logic deep);
		flash_cmd_pkg::cmd_info_type d;
		d = '0;
		d.lanes_addr = quad ? 3'h4 : 3'h1;
		d.lanes_data = quad ? 3'h4 : 3'h1;
		case (op)
			`OP_NO_OPERATION, `OP_RESET_ARM, `OP_RESET, `OP_QUAD_OFF,
			`OP_SET_LATCH, `OP_CLEAR_LATCH, `OP_ERASE_ALL_A, `OP_ERASE_ALL_B,
			`OP_SUSPEND, `OP_RESUME, `OP_LOCK_PROT, `OP_LOCK_SID, `OP_DEEP_SLEEP: begin
				d.ok = 1'b1;
			end
			`OP_QUAD_ON: begin
				d.ok = ~quad;
			end
			`OP_READ_STATUS: begin
				d.ok = 1'b1;
				d.dummy_bytes = quad ? 2'h1 : 2'h0;
				d.has_data = 1'b1;
				d.data_out = 1'b1;
			end
			`OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K: begin
				d.ok = 1'b1;
				d.addr_bytes = 2'h3;
			end
			`OP_PAGE_PROGRAM: begin
				d.ok = 1'b1;
				d.addr_bytes = 2'h3;
				d.has_data = 1'b1;
			end
			`OP_QUAD_PROGRAM: begin
				d.ok = ~quad & quad_io_enable_bit;
				d.addr_bytes = 2'h3;
				d.has_data = 1'b1;
				d.lanes_data = 3'h4;
			end
			`OP_READ_SID: begin
				d.ok = 1'b1;
				d.addr_bytes = 2'h2;
				d.dummy_bytes = quad ? 2'h3 : 2'h1;
				d.has_data = 1'b1;
				d.data_out = 1'b1;
			end
			`OP_PROGRAM_SID: begin
				d.ok = 1'b1;
				d.addr_bytes = 2'h2;
				d.has_data = 1'b1;
			end
			`OP_WAKE_ID: begin
				d.ok = 1'b1;
				d.addr_bytes = 2'h3;
				d.has_data = 1'b1;
				d.data_out = 1'b1;
			end
			`OP_READ: begin
				d.ok = ~quad;
				d.addr_bytes = 2'h3;
				d.has_data = 1'b1;
				d.data_out = 1'b1;
			end
			`OP_FAST_READ: begin
				d.ok = 1'b1;
				d.addr_bytes = 2'h3;
				d.dummy_bytes = quad ? 2'h3 : 2'h1;
				d.has_data = 1'b1;
				d.data_out = 1'b1;
			end
			`OP_DUAL_OUT_READ, `OP_DUAL_IO_READ: begin
				d.ok = ~quad;
				d.addr_bytes = 2'h3;
				d.dummy_bytes = 2'h1;
				d.has_data = 1'b1;
				d.data_out = 1'b1;
				d.lanes_data = 3'h2;
				if (op == `OP_DUAL_IO_READ) begin
					d.lanes_addr = 3'h2;
				end
			end
			`OP_QUAD_IO_READ: begin
				d.ok = ~quad & quad_io_enable_bit;
				d.addr_bytes = 2'h3;
				d.dummy_bytes = 2'h3;
				d.has_data = 1'b1;
				d.data_out = 1'b1;
				d.lanes_addr = 3'h4;
				d.lanes_data = 3'h4;
			end
			default: begin
				d.ok = 1'b0;
			end
		endcase
		// asleep, only the wake command is heard
		if (deep && op != `OP_WAKE_ID) begin
			d.ok = 1'b0;
		end
		return d;
	endfunction : decode

	// ---------------------------------------------------------------
	// byte assembly from the sampled lines
	// ---------------------------------------------------------------
	logic [7:0] shift_next;
	logic [3:0] bit_cnt_next;
	logic byte_done;
	flash_cmd_pkg::cmd_info_type op_info;

	always_comb begin
		case (lanes_reg)
			3'h4: shift_next = {shift_reg[3:0], sio_in};
			3'h2: shift_next = {shift_reg[5:0], sio_in[1:0]};
			default: shift_next = {shift_reg[6:0], sio_in[0]};
		endcase
		bit_cnt_next = bit_cnt_reg + {1'b0, lanes_reg};
		byte_done = bit_cnt_next[3];
		op_info = decode(shift_next, flags_reg.quad_mode, quad_io_en_reg, flags_reg.deep_sleep);
	end

	// ---------------------------------------------------------------
	// phase machine, advanced on serial clock rising edges
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			phase_reg <= flash_cmd_pkg::PH_IDLE;
			info_reg <= '0;
			lanes_reg <= 3'h1;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			left_reg <= 2'h0;
			op_reg <= 8'h00;
			op_seen_reg <= 1'b0;
			done_reg <= 1'b0;
			addr_reg <= 24'h000000;
			count_reg <= 11'h000;
		end else if (ce_i) begin
			if (cs_n) begin
				phase_reg <= flash_cmd_pkg::PH_IDLE;
			end else if (cs_fall) begin
				phase_reg <= flash_cmd_pkg::PH_OPCODE;
				lanes_reg <= flags_reg.quad_mode ? 3'h4 : 3'h1;
				bit_cnt_reg <= 4'h0;
				op_seen_reg <= 1'b0;
				done_reg <= 1'b0;
				count_reg <= 11'h000;
			end else if (sck_rise) begin
				shift_reg <= shift_next;
				bit_cnt_reg <= byte_done ? 4'h0 : bit_cnt_next;
				case (phase_reg)
					flash_cmd_pkg::PH_OPCODE: begin
						if (byte_done) begin
							op_reg <= shift_next;
							op_seen_reg <= 1'b1;
							info_reg <= op_info;
							if (!op_info.ok) begin
								phase_reg <= flash_cmd_pkg::PH_REJECT;
							end else if (op_info.addr_bytes != 2'h0) begin
								phase_reg <= flash_cmd_pkg::PH_ADDR;
								left_reg <= op_info.addr_bytes;
								lanes_reg <= op_info.lanes_addr;
							end else if (op_info.dummy_bytes != 2'h0) begin
								phase_reg <= flash_cmd_pkg::PH_DUMMY;
								left_reg <= op_info.dummy_bytes;
								lanes_reg <= op_info.lanes_addr;
							end else if (op_info.has_data) begin
								phase_reg <= flash_cmd_pkg::PH_DATA;
								lanes_reg <= op_info.lanes_data;
								done_reg <= 1'b1;
							end else begin
								phase_reg <= flash_cmd_pkg::PH_HOLD;
								done_reg <= 1'b1;
							end
						end
					end
					flash_cmd_pkg::PH_ADDR: begin
						if (byte_done) begin
							addr_reg <= {addr_reg[15:0], shift_next};
							left_reg <= left_reg - 2'h1;
							if (left_reg == 2'h1) begin
								if (info_reg.dummy_bytes != 2'h0) begin
									phase_reg <= flash_cmd_pkg::PH_DUMMY;
									left_reg <= info_reg.dummy_bytes;
								end else if (info_reg.has_data) begin
									phase_reg <= flash_cmd_pkg::PH_DATA;
									lanes_reg <= info_reg.lanes_data;
									done_reg <= 1'b1;
								end else begin
									phase_reg <= flash_cmd_pkg::PH_HOLD;
									done_reg <= 1'b1;
								end
							end
						end
					end
					flash_cmd_pkg::PH_DUMMY: begin
						if (byte_done) begin
							left_reg <= left_reg - 2'h1;
							if (left_reg == 2'h1) begin
								phase_reg <= flash_cmd_pkg::PH_DATA;
								lanes_reg <= info_reg.lanes_data;
								done_reg <= 1'b1;
							end
						end
					end
					flash_cmd_pkg::PH_DATA: begin
						// program data is not stored here; only whole bytes are counted
						if (byte_done && count_reg != `COUNT_SAT) begin
							count_reg <= count_reg + 11'h001;
						end
					end
					flash_cmd_pkg::PH_HOLD, flash_cmd_pkg::PH_REJECT: begin
						phase_reg <= phase_reg;
					end
					default: begin
						phase_reg <= flash_cmd_pkg::PH_IDLE;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// serial output, driven on serial clock falling edges
	// ---------------------------------------------------------------
	logic [7:0] out_byte;
	logic [7:0] out_src;

	always_comb begin
		case (op_reg)
			`OP_READ_STATUS: out_byte = {flags_reg.suspended, 5'h00, flags_reg.write_latch,
				flags_reg.busy};
			`OP_WAKE_ID: out_byte = `WAKE_ID_BYTE;
			default: out_byte = data_reg;
		endcase
		out_src = (out_cnt_reg == 4'h0) ? out_byte : out_sh_reg;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			out_sh_reg <= 8'h00;
			out_cnt_reg <= 4'h0;
			sio_o <= 4'h0;
			sio_oe_o <= 4'h0;
		end else if (ce_i) begin
			if (cs_n || phase_reg != flash_cmd_pkg::PH_DATA || !info_reg.data_out) begin
				out_cnt_reg <= 4'h0;
				sio_oe_o <= 4'h0;
			end else if (sck_fall) begin
				// a fresh byte is fetched each time the last one runs out, so reads stream
				case (lanes_reg)
					3'h4: begin
						sio_o <= out_src[7:4];
						sio_oe_o <= 4'hF;
						out_sh_reg <= {out_src[3:0], 4'h0};
						out_cnt_reg <= (out_cnt_reg == 4'h0) ? 4'h4 : out_cnt_reg - 4'h4;
					end
					3'h2: begin
						sio_o <= {2'h0, out_src[7:6]};
						sio_oe_o <= 4'h3;
						out_sh_reg <= {out_src[5:0], 2'h0};
						out_cnt_reg <= (out_cnt_reg == 4'h0) ? 4'h6 : out_cnt_reg - 4'h2;
					end
					default: begin
						sio_o <= {2'h0, out_src[7], 1'b0};
						sio_oe_o <= 4'h2;
						out_sh_reg <= {out_src[6:0], 1'b0};
						out_cnt_reg <= (out_cnt_reg == 4'h0) ? 4'h7 : out_cnt_reg - 4'h1;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// command execution at chip select release
	// ---------------------------------------------------------------
	wire logic exec = cs_rise && done_reg && info_reg.ok;
	wire logic [18:0] addr_in = addr_reg[`TOP_ADDR_BIT:0];
	wire logic bus_ack = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
	wire logic ctrl_wr = bus_ack && avs_write_i && avs_address_i == `REG_CTRL;
	wire logic may_write = flags_reg.write_latch && !flags_reg.busy;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			flags_reg <= '0;
			quad_io_en_reg <= 1'b0;
			last_op_reg <= 8'h00;
			last_ok_reg <= 1'b0;
			last_addr_reg <= 19'h00000;
			last_count_reg <= 11'h000;
			exec_cnt_reg <= 16'h0000;
		end else if (ce_i) begin
			// software side first, so a command in the same cycle wins
			if (ctrl_wr) begin
				quad_io_en_reg <= avs_writedata_i[`CTRL_QUAD_IO_EN];
				if (avs_writedata_i[`CTRL_BUSY_DONE]) begin
					flags_reg.busy <= 1'b0;
					flags_reg.suspended <= 1'b0;
				end
			end
			if (cs_rise && op_seen_reg) begin
				flags_reg.reset_armed <= 1'b0;
			end
			if (exec) begin
				last_op_reg <= op_reg;
				last_count_reg <= count_reg;
				exec_cnt_reg <= exec_cnt_reg + 16'h0001;
				last_ok_reg <= 1'b1;
				case (op_reg)
					`OP_RESET_ARM: flags_reg.reset_armed <= 1'b1;
					`OP_RESET: begin
						if (flags_reg.reset_armed) begin
							flags_reg <= '0;
							quad_io_en_reg <= 1'b0;
						end
					end
					`OP_QUAD_ON: flags_reg.quad_mode <= 1'b1;
					`OP_QUAD_OFF: flags_reg.quad_mode <= 1'b0;
					`OP_SET_LATCH: flags_reg.write_latch <= 1'b1;
					`OP_CLEAR_LATCH: flags_reg.write_latch <= 1'b0;
					`OP_ERASE_4K: begin
						if (may_write) begin
							flags_reg.busy <= 1'b1;
							flags_reg.write_latch <= 1'b0;
							last_addr_reg <= {addr_in[18:`SECTOR_LOW_BIT], 12'h000};
						end
					end
					`OP_ERASE_32K: begin
						if (may_write) begin
							flags_reg.busy <= 1'b1;
							flags_reg.write_latch <= 1'b0;
							last_addr_reg <= {addr_in[18:`BLOCK32_LOW_BIT], 15'h0000};
						end
					end
					`OP_ERASE_64K: begin
						if (may_write) begin
							flags_reg.busy <= 1'b1;
							flags_reg.write_latch <= 1'b0;
							last_addr_reg <= {addr_in[18:`BLOCK64_LOW_BIT], 16'h0000};
						end
					end
					`OP_ERASE_ALL_A, `OP_ERASE_ALL_B: begin
						if (may_write) begin
							flags_reg.busy <= 1'b1;
							flags_reg.write_latch <= 1'b0;
							last_addr_reg <= 19'h00000;
						end
					end
					`OP_PAGE_PROGRAM, `OP_QUAD_PROGRAM: begin
						// a page program needs at least one data byte
						if (may_write && count_reg != 11'h000) begin
							flags_reg.busy <= 1'b1;
							flags_reg.write_latch <= 1'b0;
							last_addr_reg <= addr_in;
						end
						if (count_reg > `PAGE_MAX_BYTES) begin
							last_count_reg <= `PAGE_MAX_BYTES;
						end
					end
					`OP_PROGRAM_SID: begin
						if (may_write && !flags_reg.sid_locked && count_reg != 11'h000) begin
							flags_reg.busy <= 1'b1;
							flags_reg.write_latch <= 1'b0;
							last_addr_reg <= {3'h0, addr_reg[15:0]};
						end
						if (count_reg > `PAGE_MAX_BYTES) begin
							last_count_reg <= `PAGE_MAX_BYTES;
						end
					end
					`OP_READ_SID: begin
						last_addr_reg <= {3'h0, addr_reg[15:0]};
						if (count_reg > `SID_MAX_BYTES) begin
							last_count_reg <= `SID_MAX_BYTES;
						end
					end
					`OP_SUSPEND: begin
						if (flags_reg.busy) begin
							flags_reg.suspended <= 1'b1;
							flags_reg.busy <= 1'b0;
						end
					end
					`OP_RESUME: begin
						if (flags_reg.suspended) begin
							flags_reg.suspended <= 1'b0;
							flags_reg.busy <= 1'b1;
						end
					end
					`OP_LOCK_PROT: flags_reg.prot_locked <= 1'b1;
					`OP_LOCK_SID: flags_reg.sid_locked <= 1'b1;
					`OP_DEEP_SLEEP: flags_reg.deep_sleep <= 1'b1;
					`OP_WAKE_ID: flags_reg.deep_sleep <= 1'b0;
					default: last_ok_reg <= 1'b1;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// register bus slave: one wait cycle on every access
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
			data_reg <= 8'h00;
		end else if (ce_i) begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
			if (bus_ack && avs_write_i && avs_address_i == `REG_DATA) begin
				data_reg <= avs_writedata_i[7:0];
			end
			if (avs_read_i && avs_waitrequest_o) begin
				case (avs_address_i)
					`REG_CTRL: avs_readdata_o <= {31'h00000000, quad_io_en_reg};
					`REG_STATE: avs_readdata_o <= {24'h000000, flags_reg};
					`REG_ADDR: avs_readdata_o <= {13'h0000, last_addr_reg};
					`REG_CMD: avs_readdata_o <= {5'h00, last_count_reg, 7'h00, last_ok_reg,
						last_op_reg};
					`REG_DATA: avs_readdata_o <= {24'h000000, data_reg};
					`REG_EXEC: avs_readdata_o <= {16'h0000, exec_cnt_reg};
					default: avs_readdata_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule : flash_cmd_decoder

/* File: bench/flash_cmd_decoder_asserts.sv */
// port assertions for the flash command decoder
// assumes bind to flash_cmd_decoder, ce_i held high
`timescale 1ns/1ps
module flash_cmd_decoder_asserts (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic cs_n_pin_i, // select
	input wire logic sck_pin_i, // sck
	input wire logic [3:0] sio_o, // data
	input wire logic [3:0] sio_oe_o, // enables
	input wire logic [4:0] avs_address_i, // addr
	input wire logic avs_read_i, // read
	input wire logic avs_write_i, // write
	input wire logic [31:0] avs_readdata_o, // rdata
	input wire logic avs_waitrequest_o // wait
);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic rd_ok = avs_read_i && !avs_waitrequest_o;
	AST_ADDR_TOP: assert property (rd_ok && avs_address_i == 5'h08 |->
		!(|avs_readdata_o[31:19]))
		else $error("address above array");
	AST_COUNT_CAP: assert property (rd_ok && avs_address_i == 5'h0C &&
		avs_readdata_o[7:0] == 8'h88 |-> avs_readdata_o[26:16] <= 11'h400)
		else $error("count over cap");
	AST_UNMAPPED: assert property (rd_ok && avs_address_i == 5'h18 |-> avs_readdata_o == 32'h0)
		else $error("unmapped not zero");
	AST_WAIT_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
		!avs_waitrequest_o)
		else $error("no answer");
	AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait low too long");
	AST_OE_IDLE: assert property (cs_n_pin_i [*6] |-> sio_oe_o == 4'h0)
		else $error("drive outside frame");
	AST_OE_LANES: assert property (sio_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("bad lane set");
	// output may only move after an sck fall, so a still link holds it
	AST_SIO_HOLD: assert property (($stable(sck_pin_i) && $stable(cs_n_pin_i)) [*8] |=>
		$stable(sio_o))
		else $error("data moved without sck");
endmodule : flash_cmd_decoder_asserts
bind flash_cmd_decoder flash_cmd_decoder_asserts i_flash_cmd_decoder_asserts (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .cs_n_pin_i(cs_n_pin_i), .sck_pin_i(sck_pin_i), .sio_o(sio_o),
	.sio_oe_o(sio_oe_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o));

/* File: bench/flash_host_model.sv */
// host flash controller model: frames, bytes out, bytes in on line 1
// assumes an 80 ns sck made from four clk_i cycles per half period
`timescale 1ns/1ps
module flash_host_model (
	input wire logic clk_i, // clock
	output logic cs_n_o, // select, active low
	output logic sck_o, // sck, still between frames
	output logic [3:0] sio_o, // lines towards device
	input wire logic [3:0] sio_i // resolved lines
);
	// ---------------------------------------------------------------
	// link tasks
	// ---------------------------------------------------------------
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		sio_o = 4'h0;
	end
	task hw;
		repeat (4) @(posedge clk_i);
	endtask : hw
	task cs_low;
		cs_n_o <= 1'b0;
		hw();
	endtask : cs_low
	// released lines flip so a stale bit never reads as valid
	task cs_high;
		hw();
		cs_n_o <= 1'b1;
		sio_o <= ~sio_o;
		repeat (2) hw();
	endtask : cs_high
	task put(input logic [7:0] b, input bit qd);
		int i;
		for (i = 0; i < (qd ? 2 : 8); i++) begin
			sio_o <= qd ? b[7:4] : {3'h0, b[7]};
			b = qd ? b << 4 : b << 1;
			hw();
			sck_o <= 1'b1;
			hw();
			sck_o <= 1'b0;
		end
	endtask : put
	task get(output logic [7:0] b);
		int i;
		sio_o <= ~sio_o;
		for (i = 0; i < 8; i++) begin
			hw();
			sck_o <= 1'b1;
			hw();
			b = {b[6:0], sio_i[1]};
			sck_o <= 1'b0;
		end
	endtask : get
endmodule : flash_host_model

/* File: bench/tb_flash_write_protect_power_cmd_decoder.sv */
// self-checking bench for the flash command decoder
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_flash_write_protect_power_cmd_decoder;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata, q;
	logic cs_n, sck, wt;
	logic [3:0] hs, ds, doe, ln;
	int error_cnt = 0;
	int n_tests = 0;
	assign ln = (doe & ds) | (~doe & hs);
	always #5 clk_i = ~clk_i;
	flash_host_model i_flash_host_model (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck),
		.sio_o(hs), .sio_i(ln));
	flash_cmd_decoder i_flash_cmd_decoder (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.cs_n_pin_i(cs_n), .sck_pin_i(sck), .sio_pin_i(ln), .sio_o(ds), .sio_oe_o(doe),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wt));
	// ---------------------------------------------------------------
	// tasks and scenarios
	// ---------------------------------------------------------------
	task summarize;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (wt === 1'b0) break;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 20) begin
			error_cnt++;
			$display("ERROR %0t bus timeout", $time);
			summarize();
		end
	endtask : bus
	task rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rchk
	task cmd(input logic [31:0] w, input int n, input bit qd);
		int i;
		i_flash_host_model.cs_low();
		for (i = 0; i < n; i++) i_flash_host_model.put(w[31-8*i -: 8], qd);
		i_flash_host_model.cs_high();
	endtask : cmd
	task t_latch;
		cmd(32'h06000000, 1, 0);
		rchk(5'h04, 32'h1, 32'h1);
		cmd(32'h04000000, 1, 0);
		rchk(5'h04, 32'h1, 32'h0);
		rchk(5'h18, 32'hFFFFFFFF, 32'h0);
		$display("latch test done");
	endtask : t_latch
	task t_erase;
		logic [7:0] op [4];
		logic [18:0] al [4];
		int k;
		op = '{8'h20, 8'h52, 8'hD8, 8'h60};
		al = '{19'h7F000, 19'h78000, 19'h70000, 19'h00000};
		for (k = 0; k < 4; k++) begin
			cmd(32'h06000000, 1, 0);
			cmd({op[k], 24'hFFFFFF}, (k == 3) ? 1 : 4, 0);
			rchk(5'h08, 32'h7FFFF, {13'h0, al[k]});
			rchk(5'h0C, 32'hFF, {24'h0, op[k]});
			rchk(5'h04, 32'h2, 32'h2);
			cmd(32'hB0000000, 1, 0);
			rchk(5'h04, 32'h6, 32'h4);
			cmd(32'h30000000, 1, 0);
			rchk(5'h04, 32'h6, 32'h2);
			bus(1'b1, 5'h00, 32'h2);
		end
		$display("erase test done");
	endtask : t_erase
	task t_status;
		logic [7:0] b0, b1;
		cmd(32'h06000000, 1, 0);
		i_flash_host_model.cs_low();
		i_flash_host_model.put(8'h05, 0);
		i_flash_host_model.get(b0);
		i_flash_host_model.get(b1);
		i_flash_host_model.cs_high();
		chk({24'h0, b0}, 32'h2);
		chk({24'h0, b1}, 32'h2);
		$display("status test done");
	endtask : t_status
	task t_reset;
		cmd(32'h66000000, 1, 0);
		rchk(5'h04, 32'h41, 32'h41);
		cmd(32'h00000000, 1, 0);
		rchk(5'h04, 32'h41, 32'h01);
		cmd(32'h99000000, 1, 0);
		rchk(5'h04, 32'h1, 32'h1);
		cmd(32'h8D000000, 1, 0);
		cmd(32'h85000000, 1, 0);
		cmd(32'hB9000000, 1, 0);
		rchk(5'h04, 32'h38, 32'h38);
		cmd(32'hAB000000, 4, 0);
		rchk(5'h04, 32'h20, 32'h0);
		cmd(32'h66000000, 1, 0);
		cmd(32'h99000000, 1, 0);
		rchk(5'h04, 32'hFF, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task t_quad;
		cmd(32'h38000000, 1, 0);
		rchk(5'h04, 32'h80, 32'h80);
		cmd(32'h06000000, 1, 1);
		rchk(5'h04, 32'h81, 32'h81);
		cmd(32'h32FFFFFF, 4, 1);
		rchk(5'h0C, 32'hFF, 32'h06);
		cmd(32'hFF000000, 1, 1);
		rchk(5'h04, 32'h80, 32'h0);
		$display("quad test done");
	endtask : t_quad
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_latch();
		t_erase();
		t_status();
		t_reset();
		t_quad();
		summarize();
	end
endmodule : tb_flash_write_protect_power_cmd_decoder
